// ===== src/prs_reset_seq.sv
`default_nettype none

// Summary of operation
// [R1] Hold internal reset while supply is below the power-on clear threshold.
// [R2] Keep the oscillator stopped whenever either reset source is active.
// [R3] After release, count stabilisation cycles before entering normal operation.
// [R4] Supply-drop reset acts only while its enable flag is set.
// [R5] An enabled supply drop holds reset continuously until the supply recovers.
// [R6] On supply recovery, release reset and run the stabilisation wait.
// [R7] Power-on reset takes precedence over the supply-drop path.
// [R8] After the wait, execution starts at program address zero.
// [R9] After drop circuitry stopped, also wait for supply at operating minimum.
// [R10] The stabilisation wait lasts 512 times 256 system clock cycles.
// [R11] Both sources merge into one reset driving oscillator stop and counter start.
module prs_reset_seq #(
    parameter int unsigned WAIT_CYCLES = prs_pkg::PRS_WAIT_COUNT
) (
    input  wire logic                          core_clk_in,
    input  wire logic                          rst_n_in,
    input  wire logic                          por_active_in,
    input  wire logic                          supply_drop_in,
    input  wire logic                          supply_drop_reset_enable_flag_in,
    input  wire logic                          drop_circuit_stopped_in,
    input  wire logic                          supply_below_min_in,
    output logic                               internal_reset_out,
    output logic                               osc_stop_out,
    output logic                               stab_wait_out,
    output logic                               normal_op_out,
    output logic                               exec_start_out,
    output logic [prs_pkg::PRS_ADDR_W-1:0]     exec_addr_out
);

    localparam int unsigned CW = $clog2(WAIT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(WAIT_CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.

    logic                          rst_meta;
    logic                          rst_sync_n;
    logic [prs_pkg::PRS_SYNC_W-1:0] sync_meta;
    logic [prs_pkg::PRS_SYNC_W-1:0] sync_q;
    logic [prs_pkg::PRS_SYNC_W-1:0] raw_in;

    // Reset asserts at once and is released two edges later.
    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign raw_in = {supply_below_min_in, drop_circuit_stopped_in,
                     supply_drop_reset_enable_flag_in, supply_drop_in, por_active_in};

    // Comparator outputs are asynchronous; power-on is assumed active at reset.
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            sync_meta <= prs_pkg::PRS_SYNC_RST;
            sync_q    <= prs_pkg::PRS_SYNC_RST;
        end
        else
        begin
            sync_meta <= raw_in;
            sync_q    <= sync_meta;
        end
    end

    logic por_s;
    logic drop_s;
    logic en_s;
    logic stop_s;
    logic lowmin_s;

    assign por_s    = sync_q[prs_pkg::PRS_BIT_POR];
    assign drop_s   = sync_q[prs_pkg::PRS_BIT_DROP];
    assign en_s     = sync_q[prs_pkg::PRS_BIT_EN];
    assign stop_s   = sync_q[prs_pkg::PRS_BIT_STOP];
    assign lowmin_s = sync_q[prs_pkg::PRS_BIT_LOWMIN];

    ////////////////////////////////////////////////////////////////////////////
    // Merged reset request.

    logic reset_req;

    // [R1] [R4] [R7] [R11] merge both sources
    // Power-on wins regardless of the flag; the drop path is gated by it.
    assign reset_req = por_s | (drop_s & en_s);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state, counter and stop memory.

    prs_pkg::prs_state_e state;
    prs_pkg::prs_state_e next_state;
    logic [CW-1:0] cnt;
    logic          stop_seen;
    logic          wait_done;

    // [R9] extra supply check
    // Once the drop circuitry has given up, the count alone cannot prove the
    // supply is usable again, so the operating minimum is also required.
    assign wait_done = (cnt == CNT_LAST) && !(stop_seen && lowmin_s);

    // Next-state decode.
    always_comb
    begin
        next_state = state;
        case (state)
            prs_pkg::PRS_HOLD:
                // [R6] release into wait
                if (!reset_req)
                    next_state = prs_pkg::PRS_WAIT;
            prs_pkg::PRS_WAIT:
                if (reset_req)
                    next_state = prs_pkg::PRS_HOLD;
                // [R3] gate on count
                else if (wait_done)
                    next_state = prs_pkg::PRS_RUN;
            prs_pkg::PRS_RUN:
                // [R5] drop holds reset
                if (reset_req)
                    next_state = prs_pkg::PRS_HOLD;
            default:
                next_state = prs_pkg::PRS_HOLD;
        endcase
    end

    // State register.
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state <= prs_pkg::PRS_HOLD;
        else
            state <= next_state;
    end

    // [R10] [R11] stabilisation counter
    // Cleared by reset; saturates on its last value until the supply is fine.
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            cnt <= CNT_ZERO;
        else if (state != prs_pkg::PRS_WAIT || reset_req)
            cnt <= CNT_ZERO;
        else if (cnt != CNT_LAST)
            cnt <= cnt + CNT_ONE;
    end

    // Remembers that the drop circuitry stopped during this reset episode.
    // A stop reported in the cycle that enters run wins over the clear, but the next cycle in run clears it.
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            stop_seen <= 1'b0;
        else if (por_s)
            stop_seen <= 1'b0;
        else if (stop_s)
            stop_seen <= 1'b1;
        else if (next_state == prs_pkg::PRS_RUN)
            stop_seen <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops.

    // [R2] [R8] outputs follow next state
    always_ff @(posedge core_clk_in or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            internal_reset_out <= 1'b1;
            osc_stop_out       <= 1'b1;
            stab_wait_out      <= 1'b0;
            normal_op_out      <= 1'b0;
            exec_start_out     <= 1'b0;
            exec_addr_out      <= prs_pkg::PRS_START_ADDR;
        end
        else
        begin
            internal_reset_out <= (next_state == prs_pkg::PRS_HOLD);
            osc_stop_out       <= (next_state == prs_pkg::PRS_HOLD);
            stab_wait_out      <= (next_state == prs_pkg::PRS_WAIT);
            normal_op_out      <= (next_state == prs_pkg::PRS_RUN);
            exec_start_out     <= (next_state == prs_pkg::PRS_RUN) && (state != prs_pkg::PRS_RUN);
            exec_addr_out      <= prs_pkg::PRS_START_ADDR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_release;
        reset_req ##1 !reset_req;
    endsequence

    sequence s_run_rise;
        !normal_op_out ##1 normal_op_out;
    endsequence

    a_por_holds_reset: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R1]
        por_s |=> internal_reset_out)
        else $error("Power-on active but internal reset not held.");

    a_osc_stopped: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R2]
        reset_req |=> osc_stop_out && internal_reset_out)
        else $error("Oscillator running during reset.");

    a_run_after_count: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R3]
        $rose(normal_op_out) |-> $past(cnt) == CNT_LAST && $past(stab_wait_out))
        else $error("Normal operation entered before wait completed.");

    a_drop_gated: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R4]
        (!por_s && !en_s) |=> !internal_reset_out)
        else $error("Disabled supply drop produced a reset.");

    a_drop_holds: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R5]
        (drop_s && en_s) [*3] |=> internal_reset_out [*1])
        else $error("Enabled supply drop did not hold reset.");

    a_release_wait: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R6]
        s_release |=> stab_wait_out && !internal_reset_out)
        else $error("Reset release did not start the wait.");

    a_por_priority: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R7]
        (por_s && !en_s) |=> ##1 !normal_op_out)
        else $error("Power-on did not take precedence.");

    a_start_addr: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R8]
        s_run_rise |-> exec_start_out && exec_addr_out == prs_pkg::PRS_START_ADDR)
        else $error("Execution did not start at address zero.");

    a_min_supply: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R9]
        $rose(normal_op_out) |-> !($past(stop_seen) && $past(lowmin_s)))
        else $error("Resumed below operating minimum after drop stop.");

    a_wait_length: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R10]
        (state == prs_pkg::PRS_WAIT && !reset_req && cnt == CNT_ZERO) |=> cnt == CNT_ONE || reset_req)
        else $error("Stabilisation counter did not advance.");

    a_merge_clears: assert property (@(posedge core_clk_in) disable iff (!rst_sync_n) // [R11]
        internal_reset_out |-> osc_stop_out && cnt == CNT_ZERO)
        else $error("Merged reset did not stop oscillator and counter.");

endmodule : prs_reset_seq

`default_nettype wire

// ===== src/prs_pkg.sv
`default_nettype none

package prs_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [2:0]
    {
        PRS_HOLD = 3'h1,
        PRS_WAIT = 3'h2,
        PRS_RUN  = 3'h4
    } prs_state_e;

    // Stabilisation wait factors, in system clock cycles.
    localparam int unsigned PRS_WAIT_MUL   = 512;
    localparam int unsigned PRS_WAIT_UNIT  = 256;
    localparam int unsigned PRS_WAIT_COUNT = PRS_WAIT_MUL * PRS_WAIT_UNIT;

    // Program address where execution restarts.
    localparam int unsigned PRS_ADDR_W     = 11;
    localparam logic [PRS_ADDR_W-1:0] PRS_START_ADDR = 11'h000;

    // Synchroniser input bit positions.
    localparam int unsigned PRS_SYNC_W     = 5;
    localparam int unsigned PRS_BIT_POR    = 0;
    localparam int unsigned PRS_BIT_DROP   = 1;
    localparam int unsigned PRS_BIT_EN     = 2;
    localparam int unsigned PRS_BIT_STOP   = 3;
    localparam int unsigned PRS_BIT_LOWMIN = 4;
    localparam logic [PRS_SYNC_W-1:0] PRS_SYNC_RST = 5'h01;

endpackage : prs_pkg

`default_nettype wire

// ===== sim/test_prs_reset_seq.sv
`default_nettype none

module test_prs_reset_seq;
    timeunit 1ns;
    timeprecision 1ps;

    // A short wait keeps the run brief; every expectation is derived from it.
    localparam int unsigned WAIT_N = 16;

    logic                          core_clk;
    logic                          rst_n;
    logic                          por;
    logic                          drop;
    logic                          en;
    logic                          stopped;
    logic                          below_min;
    logic                          int_rst;
    logic                          osc_stop;
    logic                          stab_wait;
    logic                          normal_op;
    logic                          exec_start;
    logic [prs_pkg::PRS_ADDR_W-1:0] exec_addr;
    int                            fail_count;
    int                            checks_done;

    ////////////////////////////////////////////////////////////////////////////
    prs_reset_seq #(
        .WAIT_CYCLES(WAIT_N)
    ) u_prs_reset_seq (
        .core_clk_in                      (core_clk),
        .rst_n_in                         (rst_n),
        .por_active_in                    (por),
        .supply_drop_in                   (drop),
        .supply_drop_reset_enable_flag_in (en),
        .drop_circuit_stopped_in          (stopped),
        .supply_below_min_in              (below_min),
        .internal_reset_out               (int_rst),
        .osc_stop_out                     (osc_stop),
        .stab_wait_out                    (stab_wait),
        .normal_op_out                    (normal_op),
        .exec_start_out                   (exec_start),
        .exec_addr_out                    (exec_addr)
    );

    // Free-running system clock at 100 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compares one value and counts it; four-state equality so an X only matches an expected X.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cycles

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    // Waits for normal operation under a bound; checks the wait length when asked.
    task automatic check_run(input int exp_n);
        int n;
        int k;
        n = 0;
        for (k = 0; k < 300 && normal_op !== 1'b1; k++)
        begin
            @(negedge core_clk);
            if (stab_wait === 1'b1)
                n++;
        end
        if (exp_n > 0)
            check(n, exp_n);
        check(normal_op, 1'b1);
        check(exec_start, 1'b1);
        check(exec_addr, '0);
        check({int_rst, osc_stop, stab_wait}, 3'h0);
        cycles(1);
        check(exec_start, 1'b0);
    endtask : check_run

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_power_on();
        check({int_rst, osc_stop}, 2'h3);
        check(normal_op, 1'b0);
        por = 1'b0;
        check_run(WAIT_N);
    endtask : test_power_on

    task automatic test_drop_disabled();
        en = 1'b0;
        drop = 1'b1;
        cycles(10);
        check({int_rst, normal_op}, 2'h1);
        drop = 1'b0;
    endtask : test_drop_disabled

    // A long enabled drop must hold reset the whole time.
    task automatic test_drop_enabled();
        en = 1'b1;
        drop = 1'b1;
        cycles(4);
        check({int_rst, osc_stop, normal_op}, 3'h6);
        cycles(20);
        check({int_rst, stab_wait}, 2'h2);
        drop = 1'b0;
        check_run(WAIT_N);
    endtask : test_drop_enabled

    // A new drop mid-wait must return to hold and restart the full count.
    task automatic test_restart_in_wait();
        drop = 1'b1;
        cycles(4);
        drop = 1'b0;
        cycles(8);
        check(stab_wait, 1'b1);
        drop = 1'b1;
        cycles(4);
        check({int_rst, osc_stop, stab_wait}, 3'h6);
        drop = 1'b0;
        check_run(WAIT_N);
    endtask : test_restart_in_wait

    // Once the drop circuitry stopped, the wait also needs the supply minimum.
    task automatic test_stopped();
        drop = 1'b1;
        stopped = 1'b1;
        below_min = 1'b1;
        cycles(6);
        drop = 1'b0;
        stopped = 1'b0;
        cycles(WAIT_N + 10);
        check({stab_wait, normal_op}, 2'h2);
        below_min = 1'b0;
        check_run(0);
    endtask : test_stopped

    // Power-on acts even with the drop path disabled.
    task automatic test_por_priority();
        en = 1'b0;
        por = 1'b1;
        cycles(4);
        check({int_rst, osc_stop}, 2'h3);
        por = 1'b0;
        check_run(WAIT_N);
    endtask : test_por_priority

    ////////////////////////////////////////////////////////////////////////////
    // Inputs change on the falling edge, away from the sampling edge.
    initial
    begin
        fail_count = 0;
        checks_done = 0;
        rst_n = 1'b0;
        por = 1'b1;
        drop = 1'b0;
        en = 1'b0;
        stopped = 1'b0;
        below_min = 1'b0;
        cycles(6);
        rst_n = 1'b1;
        cycles(4);
        test_power_on();
        test_drop_disabled();
        test_drop_enabled();
        test_restart_in_wait();
        test_stopped();
        test_por_priority();
        tally_and_finish();
    end

    // Watchdog well beyond the 180 or so cycles the tests need.
    initial
    begin
        #50000;
        fail_count++;
        tally_and_finish();
    end

endmodule : test_prs_reset_seq

`default_nettype wire
